// ---- core/orp_pkg.sv ----
// constants shared by the output reset pattern block
// assumes a single 10 MHz clock domain
package orp_pkg;
  localparam int NUM_GROUPS       = 61;
  localparam int POINTS_PER_GROUP = 32;
  localparam int FIRST_POINT      = 2000;
  localparam int LAST_POINT       = 3951;
  localparam int SETTING_W        = 2;
  localparam int PATTERN_W        = POINTS_PER_GROUP * SETTING_W;
  localparam int GROUP_SEL_W      = 6;
  localparam int NUM_POINTS       = NUM_GROUPS * POINTS_PER_GROUP;

  // per-point setting codes
  localparam logic [1:0] SET_OFF  = 2'h0;
  localparam logic [1:0] SET_ON   = 2'h1;
  localparam logic [1:0] SET_HOLD = 2'h2;
  localparam logic [1:0] SET_BAD  = 2'h3;

  localparam logic [63:0] PATTERN_RESET = 64'h0;
  localparam logic [31:0] POINTS_RESET  = 32'h0;
endpackage

// ---- core/orp_group.sv ----
// one group of 32 output points with its stored reset pattern
// assumes apply_in is a single-cycle pulse from the top
module orp_group (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // pattern setting
  input  wire logic        pattern_wr_in,
  input  wire logic [63:0] pattern_data_in,
  // normal output writes
  input  wire logic        out_wr_in,
  input  wire logic [31:0] out_data_in,
  // pattern apply
  input  wire logic        apply_in,
  // results
  output logic      [31:0] points_out,
  output logic             bad_setting_out
);

  logic [63:0] pattern;
  logic [63:0] next_pattern;
  logic [31:0] next_points;
  logic        next_bad;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] code;
    code         = orp_pkg::SET_OFF;
    next_pattern = pattern;
    next_points  = points_out;
    next_bad     = 1'b0;
    if (pattern_wr_in) begin
      next_pattern = pattern_data_in;
    end
    if (apply_in) begin
      // whole group in one cycle, apply beats a write
      for (int i = 0; i < orp_pkg::POINTS_PER_GROUP; i++) begin
        // leftmost setting is the lowest point
        code = pattern[63 - 2*i -: 2];
        unique case (code)
          orp_pkg::SET_OFF:  next_points[i] = 1'b0;
          orp_pkg::SET_ON:   next_points[i] = 1'b1;
          default:           next_points[i] = points_out[i];
        endcase
      end
    end else if (out_wr_in) begin
      next_points = out_data_in;
    end
    for (int i = 0; i < orp_pkg::POINTS_PER_GROUP; i++) begin
      if (pattern[2*i +: 2] == orp_pkg::SET_BAD) begin
        next_bad = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pattern         <= orp_pkg::PATTERN_RESET;
      points_out      <= orp_pkg::POINTS_RESET;
      bad_setting_out <= 1'b0;
    end else begin
      pattern         <= next_pattern;
      points_out      <= next_points;
      bad_setting_out <= next_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_lead_off: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    apply_in && pattern[63:62] == orp_pkg::SET_OFF |=> !points_out[0])
    else $error("off setting did not clear lowest point");

  a_lead_on: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    apply_in && pattern[63:62] == orp_pkg::SET_ON |=> points_out[0])
    else $error("on setting did not set lowest point");

  a_lead_hold: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    apply_in && pattern[63:62] == orp_pkg::SET_HOLD |=> $stable(points_out[0]))
    else $error("hold setting changed lowest point");

  a_last_order: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    apply_in && pattern[1:0] == orp_pkg::SET_ON |=> points_out[31])
    else $error("rightmost setting not mapped to highest point");

  a_pattern_default: assert property (
    @(posedge clk_in)
    !resetn_in |=> pattern == orp_pkg::PATTERN_RESET)
    else $error("pattern not cleared by reset");

  a_apply_wins: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    apply_in && out_wr_in && pattern == orp_pkg::PATTERN_RESET
      |=> points_out == orp_pkg::POINTS_RESET)
    else $error("output write broke an all-off pattern apply");
endmodule

// ---- core/orp_status.sv ----
// run and error indicator drivers
// assumes error inputs are synchronous levels or pulses
module orp_status (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // error sources
  input  wire logic wdt_error_in,
  input  wire logic param_error_in,
  input  wire logic unit_error_in,
  // indicators
  output logic      run_led_out,
  output logic      err_led_out
);

  logic next_run;
  logic next_err;

  always_comb begin
    // errors are sticky until reset
    next_run = run_led_out && !wdt_error_in;
    next_err = err_led_out || param_error_in || unit_error_in;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      run_led_out <= 1'b1;
      err_led_out <= 1'b0;
    end else begin
      run_led_out <= next_run;
      err_led_out <= next_err;
    end
  end
endmodule

// ---- core/orp_top.sv ----
// output reset pattern block: 61 groups of 32 general outputs
// assumes all inputs synchronous to clk_in, single-cycle command pulses

// How it works
// - factory defaults start all outputs off
// - pattern applied right after power-on reset
// - reset input and clear command apply pattern
// - 32-point groups cover outputs 2000 to 3951
// - leftmost setting is group's lowest output
// - setting off, on or hold per point
// - hold keeps the previous output state
// - pattern settings reset to all off
// - run indicator lit until watchdog error
// - error indicator lit on parameter or unit error
module orp_top (
  // clock and reset
  input  wire logic                                 clk_in,
  input  wire logic                                 resetn_in,
  // pattern setting
  input  wire logic                                 pattern_wr_in,
  input  wire logic [orp_pkg::GROUP_SEL_W-1:0]      pattern_group_in,
  input  wire logic [orp_pkg::PATTERN_W-1:0]        pattern_data_in,
  // output image writes
  input  wire logic                                 out_wr_in,
  input  wire logic [orp_pkg::GROUP_SEL_W-1:0]      out_group_in,
  input  wire logic [orp_pkg::POINTS_PER_GROUP-1:0] out_data_in,
  // reset requests
  input  wire logic                                 reset_req_in,
  input  wire logic                                 clear_cmd_in,
  // error sources
  input  wire logic                                 wdt_error_in,
  input  wire logic                                 unit_error_in,
  // outputs
  output logic      [orp_pkg::NUM_POINTS-1:0]       points_out,
  output logic                                      run_led_out,
  output logic                                      err_led_out
);

  logic                          boot_pending;
  logic                          next_boot_pending;
  logic                          apply;
  logic [orp_pkg::NUM_GROUPS-1:0] bad_setting;

  ////////////////////////////////////////////////////////////////////////
  // apply pulse: once after reset, then on request
  always_comb begin
    next_boot_pending = 1'b0;
    apply = boot_pending || reset_req_in || clear_cmd_in;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      boot_pending <= 1'b1;
    end else begin
      boot_pending <= next_boot_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // group g covers points FIRST_POINT + 32*g upward
  for (genvar g = 0; g < orp_pkg::NUM_GROUPS; g++) begin : g_grp
    orp_group u_group (
      .clk_in          (clk_in),
      .resetn_in       (resetn_in),
      .pattern_wr_in   (pattern_wr_in &&
                        pattern_group_in == orp_pkg::GROUP_SEL_W'(g)),
      .pattern_data_in (pattern_data_in),
      .out_wr_in       (out_wr_in &&
                        out_group_in == orp_pkg::GROUP_SEL_W'(g)),
      .out_data_in     (out_data_in),
      .apply_in        (apply),
      .points_out      (points_out[g*32 +: 32]),
      .bad_setting_out (bad_setting[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  orp_status u_status (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .wdt_error_in   (wdt_error_in),
    .param_error_in (|bad_setting),
    .unit_error_in  (unit_error_in),
    .run_led_out    (run_led_out),
    .err_led_out    (err_led_out)
  );

  ////////////////////////////////////////////////////////////////////////
  sequence s_reset_release;
    !resetn_in ##1 resetn_in;
  endsequence

  a_boot_apply: assert property (
    @(posedge clk_in) s_reset_release |-> apply)
    else $error("no pattern apply after reset release");

  a_boot_off: assert property (
    @(posedge clk_in) !resetn_in ##1 resetn_in ##1 resetn_in
      |-> points_out == '0)
    else $error("outputs not off after default start");

  a_request_apply: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    reset_req_in || clear_cmd_in |-> apply)
    else $error("reset request or clear did not apply pattern");

  a_run_off: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wdt_error_in |=> !run_led_out [*2])
    else $error("run indicator lit after watchdog error");

  a_err_on: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    unit_error_in |=> err_led_out)
    else $error("error indicator dark after unit error");

  a_err_quiet: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !err_led_out && !unit_error_in && !(|bad_setting) |=> !err_led_out)
    else $error("error indicator lit in normal operation");
endmodule

// ---- tb/orp_master_model.sv ----
// fieldbus master model: writes the output image group by group
// assumes a free running clk_in; changes lines at the falling edge
module orp_master_model (
  // clock
  input  wire logic        clk_in,
  // output image write
  output logic             out_wr_out,
  output logic [5:0]       out_group_out,
  output logic [31:0]      out_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    out_wr_out = 1'b0;
    out_group_out = 6'h3f;
    out_data_out = 32'h0;
  end
  task automatic send(input logic [5:0] g, input logic [31:0] d);
    @(negedge clk_in);
    out_wr_out = 1'b1;
    out_group_out = g;
    out_data_out = d;
    @(negedge clk_in);
    out_wr_out = 1'b0;
    out_group_out = ~g;
    out_data_out = ~d;
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the output reset pattern block
// assumes orp_pkg and orp_top compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                           clk_in, resetn_in, pattern_wr_in;
  logic                           reset_req_in, clear_cmd_in, out_wr_in;
  logic                           wdt_error_in, unit_error_in;
  logic                           run_led_out, err_led_out;
  logic [5:0]                     pattern_group_in, out_group_in;
  logic [63:0]                    pattern_data_in;
  logic [31:0]                    out_data_in, d32;
  logic [orp_pkg::NUM_POINTS-1:0] points_out, m_pts;
  logic [63:0]                    m_pat [61];
  int                             n_fail = 0;
  int                             compares = 0;
  int                             i;
  orp_top u_orp_top (.clk_in(clk_in), .resetn_in(resetn_in),
    .pattern_wr_in(pattern_wr_in), .pattern_group_in(pattern_group_in),
    .pattern_data_in(pattern_data_in), .out_wr_in(out_wr_in),
    .out_group_in(out_group_in), .out_data_in(out_data_in),
    .reset_req_in(reset_req_in), .clear_cmd_in(clear_cmd_in),
    .wdt_error_in(wdt_error_in), .unit_error_in(unit_error_in),
    .points_out(points_out), .run_led_out(run_led_out),
    .err_led_out(err_led_out));
  orp_master_model u_orp_master_model (.clk_in(clk_in),
    .out_wr_out(out_wr_in), .out_group_out(out_group_in),
    .out_data_out(out_data_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #(20000 * 100);
    n_fail++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check_pts(input string msg);
    compares++;
    if (points_out !== m_pts) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic check_led(input logic run, input logic err, input string msg);
    compares++;
    if (run_led_out !== run || err_led_out !== err) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // left pair of a pattern is the group's lowest point
  function automatic void m_apply();
    for (int k = 0; k < 61; k++)
      for (int p = 0; p < 32; p++)
        if (m_pat[k][63-2*p -: 2] == 2'h0) m_pts[32*k+p] = 1'b0;
        else if (m_pat[k][63-2*p -: 2] == 2'h1) m_pts[32*k+p] = 1'b1;
  endfunction
  function automatic logic [63:0] rnd_pat();
    logic [63:0] d;
    for (int p = 0; p < 32; p++) d[2*p +: 2] = 2'($urandom_range(2, 0));
    return d;
  endfunction
  task automatic set_pat(input int grp, input logic [63:0] d);
    pattern_wr_in = 1'b1;
    pattern_group_in = grp[5:0];
    pattern_data_in = d;
    tick(1);
    pattern_wr_in = 1'b0;
    pattern_data_in = ~d;
    if (grp < 61) m_pat[grp] = d;
    // idle edge so back to back writes never retoggle the strobe
    tick(1);
  endtask
  task automatic apply(input logic clr);
    reset_req_in = ~clr;
    clear_cmd_in = clr;
    tick(1);
    reset_req_in = 1'b0;
    clear_cmd_in = 1'b0;
    m_apply();
    tick(1);
  endtask
  task automatic do_reset();
    resetn_in = 1'b0;
    tick(10);
    resetn_in = 1'b1;
    m_pts = '0;
    foreach (m_pat[k]) m_pat[k] = 64'h0;
    tick(1);
  endtask
  task automatic fill_out(input int n);
    for (int k = 0; k < n; k++) begin
      i = (k == 0) ? 60 : $urandom_range(60, 0);
      d32 = $urandom();
      u_orp_master_model.send(i[5:0], d32);
      m_pts[32*i +: 32] = d32;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    {pattern_wr_in, reset_req_in, clear_cmd_in} = 3'h0;
    {wdt_error_in, unit_error_in} = 2'h0;
    pattern_group_in = 6'h0;
    pattern_data_in = 64'h0;
    i = $urandom(46);
    do_reset();
    check_pts("boot outputs");
    check_led(1'b1, 1'b0, "boot indicators");
    fill_out(8);
    check_pts("output image");
    apply(1'b0);
    check_pts("zero pattern");
    $display("test reset defaults done");
    fill_out(10);
    u_orp_master_model.send(6'h0, 32'hffff_ffff);
    m_pts[31:0] = 32'hffff_ffff;
    set_pat(0, 64'h8001_0000_5500_0000);
    for (int k = 1; k < 61; k++) set_pat(k, rnd_pat());
    set_pat(61, 64'h5555_5555_5555_5555);
    apply(1'b0);
    check_pts("reset request apply");
    fill_out(10);
    apply(1'b1);
    check_pts("clear apply");
    apply(1'b1);
    check_pts("repeated apply");
    $display("test pattern apply done");
    wdt_error_in = 1'b1;
    tick(1);
    check_led(1'b0, 1'b0, "watchdog");
    unit_error_in = 1'b1;
    tick(1);
    {wdt_error_in, unit_error_in} = 2'h0;
    tick(2);
    check_led(1'b0, 1'b1, "unit error");
    do_reset();
    check_pts("power on apply");
    check_led(1'b1, 1'b0, "indicators after reset");
    // output write and reset request meet on one edge; the write is lost
    fork
      u_orp_master_model.send(6'h3, 32'h1234_5678);
      begin
        tick(1);
        apply(1'b0);
      end
    join
    check_pts("apply beats write");
    set_pat(5, 64'h3);
    tick(1);
    check_led(1'b1, 1'b1, "illegal code");
    $display("test indicators done");
    report_and_stop();
  end
endmodule
